// >>> design/brl_pkg.sv
// Constants and types of the command link.
// Assumes users write brl_pkg:: names.
package brl_pkg;

  // Operation codes carried in byte 0 of a command block.
  localparam logic [7:0] OP_PREVENT = 8'h1E;
  localparam logic [7:0] OP_READ6   = 8'h08;
  localparam logic [7:0] OP_READ10  = 8'h28;
  localparam logic [7:0] OP_READCAP = 8'h25;

  // Command block geometry and field positions.
  localparam int CDB_BYTES   = 10;
  localparam int NUM_INIT    = 8;
  localparam int PREVENT_BIT = 0;
  localparam int DPO_BIT     = 4;
  localparam int FUA_BIT     = 3;
  localparam int RELATIVE_ADDRESS_FLAG_BIT  = 0;
  localparam int PMI_BIT     = 0;
  localparam int LINK_BIT    = 0;

  // Block count implied by a zero count on the short read.
  localparam logic [16:0] READ6_ZERO_COUNT = 17'h00100;

  // Cache handling chosen by the target for the short read.
  localparam logic READ6_LOW_PRI   = 1'b0;
  localparam logic READ6_FROM_MEDIA = 1'b0;

  // Status and sense values returned at the end of a command.
  localparam logic [7:0] STATUS_GOOD    = 8'h00;
  localparam logic [7:0] STATUS_CHECK   = 8'h02;
  localparam logic [3:0] KEY_NONE       = 4'h0;
  localparam logic [3:0] KEY_MEDIUM_ERR = 4'h3;
  localparam logic [3:0] KEY_ILLEGAL    = 4'h5;
  localparam logic [7:0] ASC_NONE       = 8'h00;
  localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
  localparam logic [7:0] ASC_BAD_FIELD  = 8'h24;

  // Byte 0 of a command block sits at index 0.
  typedef logic [CDB_BYTES-1:0][7:0] brl_cdb_t;

  // Target command sequencer; Gray steps along idle, decode, run, status.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC  = 3'b001,
    ST_RUN  = 3'b011,
    ST_STAT = 3'b010,
    ST_CAP  = 3'b110,
    ST_SYNC = 3'b111
  } brl_state_t;

  // Command kinds the initiator end can build.
  typedef enum logic [1:0] {
    CMD_PREVENT = 2'b00,
    CMD_READ6   = 2'b01,
    CMD_READ10  = 2'b11,
    CMD_READCAP = 2'b10
  } brl_cmd_t;

endpackage

// >>> design/brl_link_if.sv
// Command link between initiator and target ends.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface brl_link_if;
  logic             cdbValid;
  logic             cdbReady;
  brl_pkg::brl_cdb_t cdb;
  logic [2:0]       initId;
  logic             busDevReset;
  logic             dinValid;
  logic             dinReady;
  logic [7:0]       dinByte;
  logic             staValid;
  logic [7:0]       staCode;
  logic [3:0]       senseKey;
  logic [7:0]       senseAsc;

  // The target end answers commands and streams data in.
  modport target (
    input  cdbValid, cdb, initId, busDevReset, dinReady,
    output cdbReady, dinValid, dinByte, staValid, staCode, senseKey, senseAsc
  );

  // The initiator end issues commands and takes data and status.
  modport initiator (
    output cdbValid, cdb, initId, busDevReset, dinReady,
    input  cdbReady, dinValid, dinByte, staValid, staCode, senseKey, senseAsc
  );
endinterface
`default_nettype wire

// >>> design/brl_skid_buf.sv
// Two-entry byte buffer with valid and ready on both sides.
// Assumes a single clock; every output comes from a flip-flop.
`timescale 1ns/1ps
`default_nettype none
module brl_skid_buf (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       inValid,
  input  wire logic [7:0] inData,
  output logic            inReady,
  output logic            outValid,
  output logic [7:0]      outData,
  input  wire logic       outReady
);
  logic       spareV_q;
  logic [7:0] spare_q;
  logic       take;

  // The spare slot catches a word while the head stalls.
  assign take    = inValid && !spareV_q;
  assign inReady = !spareV_q;

  // Head refills from the spare first.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      outValid <= 1'b0;
      outData  <= 8'h00;
      spareV_q <= 1'b0;
      spare_q  <= 8'h00;
    end else if (!outValid || outReady) begin
      if (spareV_q) begin
        outData  <= spare_q;
        outValid <= 1'b1;
        spareV_q <= 1'b0;
      end else begin
        outData  <= inData;
        outValid <= take;
      end
    end else if (take) begin
      spare_q  <= inData;
      spareV_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> design/brl_target.sv
// Target end: decodes command blocks, runs reads, reports capacity, and
// keeps the per-initiator medium removal locks.
// Assumes a backend for data, cache sync and capacity.
`timescale 1ns/1ps
`default_nettype none
module brl_target (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  brl_link_if.target       link,
  output logic             rdReq,
  output logic [31:0]      rdLba,
  output logic [16:0]      rdCount,
  output logic             rdFromMedia,
  output logic             rdLowPri,
  input  wire logic [7:0]  rdDat,
  input  wire logic        rdDatValid,
  output logic             rdDatReady,
  input  wire logic        rdDone,
  input  wire logic        rdOk,
  output logic             syncReq,
  input  wire logic        syncDone,
  input  wire logic        syncOk,
  input  wire logic        deferredErr,
  input  wire logic [31:0] capLastLba,
  input  wire logic [31:0] capBlockLen,
  input  wire logic [31:0] capDelayLba,
  input  wire logic        ejectPress,
  output logic             ejectRelease,
  output logic             ejectRefused,
  output logic             mechInhibit
);
  brl_pkg::brl_state_t st_q;
  brl_pkg::brl_cdb_t   cdb_q;
  logic [2:0]          id_q;
  logic [31:0]         lastLba_q;
  logic [31:0]         capWord_q;
  logic [31:0]         capLen_q;
  logic [2:0]          capIdx_q;
  logic [7:0]          holds_q;
  logic                relPend_q;
  logic                deferPend_q;
  logic                cdbRdy_q;
  logic                staValid_q;
  logic [7:0]          staCode_q;
  logic [3:0]          senseKey_q;
  logic [7:0]          senseAsc_q;
  logic [7:0]          op;
  logic [7:0]          ctl;
  logic                linked;
  logic                badRel;
  logic [31:0]         lba10;
  logic [31:0]         effLba;
  logic [7:0]          idMask;
  logic                needSync;
  logic                locked;
  logic [16:0]         count6;
  logic [16:0]         count10;
  logic [63:0]         capAll;
  logic                bufInValid;
  logic [7:0]          bufInData;
  logic                bufInReady;

  // Four bytes starting at a given index, most significant first.
  function automatic logic [31:0] be32(input brl_pkg::brl_cdb_t c, input int s);
    be32 = {c[s], c[s+1], c[s+2], c[s+3]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field decode of the held command block.
  assign op      = cdb_q[0];
  assign ctl     = (op == brl_pkg::OP_READ6 || op == brl_pkg::OP_PREVENT) ? cdb_q[5] : cdb_q[9];
  assign linked  = ctl[brl_pkg::LINK_BIT];
  assign lba10   = be32(cdb_q, 2);
  assign badRel  = cdb_q[1][brl_pkg::RELATIVE_ADDRESS_FLAG_BIT] && !linked;
  assign effLba  = cdb_q[1][brl_pkg::RELATIVE_ADDRESS_FLAG_BIT] ? lastLba_q + lba10 : lba10;
  assign count6  = (cdb_q[4] == 8'h00) ? brl_pkg::READ6_ZERO_COUNT : {9'h000, cdb_q[4]};
  assign count10 = {1'b0, cdb_q[7], cdb_q[8]};
  assign idMask  = 8'h01 << id_q;
  // Last holder letting go, or a release awaiting a good sync.
  assign needSync = !cdb_q[4][brl_pkg::PREVENT_BIT] && ((holds_q & ~idMask) == 8'h00)
                    && (relPend_q || holds_q[id_q]);
  assign locked   = (|holds_q) || relPend_q;

  // Capacity bytes: address then length, MSB first.
  assign capAll     = {capWord_q, capLen_q};
  assign bufInValid = (st_q == brl_pkg::ST_CAP) || (st_q == brl_pkg::ST_RUN && rdDatValid);
  assign bufInData  = (st_q == brl_pkg::ST_CAP) ? capAll[{~capIdx_q, 3'b000} +: 8] : rdDat;
  assign rdDatReady = bufInReady;

  // Data-in bytes pass the two-entry buffer.
  brl_skid_buf u_buf (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .inValid  (bufInValid),
    .inData   (bufInData),
    .inReady  (bufInReady),
    .outValid (link.dinValid),
    .outData  (link.dinByte),
    .outReady (link.dinReady)
  );

  assign link.cdbReady = cdbRdy_q;
  assign link.staValid = staValid_q;
  assign link.staCode  = staCode_q;
  assign link.senseKey = senseKey_q;
  assign link.senseAsc = senseAsc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer: take, decode, run, then report status.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q        <= brl_pkg::ST_IDLE;
      cdb_q       <= '0;
      id_q        <= 3'h0;
      cdbRdy_q    <= 1'b1;
      staValid_q  <= 1'b0;
      staCode_q   <= brl_pkg::STATUS_GOOD;
      senseKey_q  <= brl_pkg::KEY_NONE;
      senseAsc_q  <= brl_pkg::ASC_NONE;
      rdReq       <= 1'b0;
      rdLba       <= 32'h00000000;
      rdCount     <= 17'h00000;
      rdFromMedia <= 1'b0;
      rdLowPri    <= 1'b0;
      syncReq     <= 1'b0;
      lastLba_q   <= 32'h00000000;
      capWord_q   <= 32'h00000000;
      capLen_q    <= 32'h00000000;
      capIdx_q    <= 3'h0;
    end else begin
      rdReq      <= 1'b0;
      syncReq    <= 1'b0;
      staValid_q <= 1'b0;
      unique case (st_q)
        brl_pkg::ST_IDLE: begin
          if (link.cdbValid) begin
            cdb_q    <= link.cdb;
            id_q     <= link.initId;
            cdbRdy_q <= 1'b0;
            st_q     <= brl_pkg::ST_DEC;
          end
        end
        brl_pkg::ST_DEC: begin
          st_q       <= brl_pkg::ST_STAT;
          staCode_q  <= brl_pkg::STATUS_GOOD;
          senseKey_q <= brl_pkg::KEY_NONE;
          senseAsc_q <= brl_pkg::ASC_NONE;
          if (deferPend_q) begin
            staCode_q  <= brl_pkg::STATUS_CHECK;
            senseKey_q <= brl_pkg::KEY_MEDIUM_ERR;
          end else if (op == brl_pkg::OP_PREVENT) begin
            if (needSync) begin
              syncReq <= 1'b1;
              st_q    <= brl_pkg::ST_SYNC;
            end
          end else if (op == brl_pkg::OP_READ6) begin
            rdReq       <= 1'b1;
            rdLba       <= {11'h000, cdb_q[1][4:0], cdb_q[2], cdb_q[3]};
            rdCount     <= count6;
            rdFromMedia <= brl_pkg::READ6_FROM_MEDIA;
            rdLowPri    <= brl_pkg::READ6_LOW_PRI;
            st_q        <= brl_pkg::ST_RUN;
          end else if ((op == brl_pkg::OP_READ10 || op == brl_pkg::OP_READCAP) && badRel) begin
            staCode_q  <= brl_pkg::STATUS_CHECK;
            senseKey_q <= brl_pkg::KEY_ILLEGAL;
            senseAsc_q <= brl_pkg::ASC_BAD_FIELD;
          end else if (op == brl_pkg::OP_READ10) begin
            if (count10 != 17'h00000) begin
              rdReq       <= 1'b1;
              rdLba       <= effLba;
              rdCount     <= count10;
              rdFromMedia <= cdb_q[1][brl_pkg::FUA_BIT];
              rdLowPri    <= cdb_q[1][brl_pkg::DPO_BIT];
              st_q        <= brl_pkg::ST_RUN;
            end
          end else if (op == brl_pkg::OP_READCAP) begin
            if (!cdb_q[8][brl_pkg::PMI_BIT] && lba10 != 32'h00000000) begin
              staCode_q  <= brl_pkg::STATUS_CHECK;
              senseKey_q <= brl_pkg::KEY_ILLEGAL;
              senseAsc_q <= brl_pkg::ASC_BAD_FIELD;
            end else begin
              if (!cdb_q[8][brl_pkg::PMI_BIT]) begin
                capWord_q <= capLastLba;
              end else begin
                capWord_q <= (capDelayLba < effLba) ? effLba : capDelayLba;
              end
              capLen_q <= capBlockLen;
              capIdx_q <= 3'h0;
              st_q     <= brl_pkg::ST_CAP;
            end
          end else begin
            staCode_q  <= brl_pkg::STATUS_CHECK;
            senseKey_q <= brl_pkg::KEY_ILLEGAL;
            senseAsc_q <= brl_pkg::ASC_BAD_OPCODE;
          end
        end
        brl_pkg::ST_RUN: begin
          // Status waits for the backend, which has finished any write-back.
          if (rdDone) begin
            lastLba_q <= rdLba + 32'(rdCount) - 32'h00000001;
            st_q      <= brl_pkg::ST_STAT;
            if (!rdOk) begin
              staCode_q  <= brl_pkg::STATUS_CHECK;
              senseKey_q <= brl_pkg::KEY_MEDIUM_ERR;
            end
          end
        end
        brl_pkg::ST_CAP: begin
          if (bufInReady) begin
            capIdx_q <= capIdx_q + 3'h1;
            if (capIdx_q == 3'h7) begin
              st_q <= brl_pkg::ST_STAT;
            end
          end
        end
        brl_pkg::ST_SYNC: begin
          if (syncDone) begin
            st_q <= brl_pkg::ST_STAT;
            if (!syncOk) begin
              staCode_q  <= brl_pkg::STATUS_CHECK;
              senseKey_q <= brl_pkg::KEY_MEDIUM_ERR;
            end
          end
        end
        brl_pkg::ST_STAT: begin
          // Status goes out only after the last data byte has left.
          if (!link.dinValid) begin
            staValid_q <= 1'b1;
            cdbRdy_q   <= 1'b1;
            st_q       <= brl_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q     <= brl_pkg::ST_IDLE;
          cdbRdy_q <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-initiator removal prevention and the pending release.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      holds_q   <= 8'h00;
      relPend_q <= 1'b0;
    end else if (link.busDevReset) begin
      holds_q   <= 8'h00;
      relPend_q <= 1'b0;
    end else if (st_q == brl_pkg::ST_DEC && op == brl_pkg::OP_PREVENT && !deferPend_q) begin
      holds_q[id_q] <= cdb_q[4][brl_pkg::PREVENT_BIT];
      if (needSync) begin
        relPend_q <= 1'b1;
      end
    end else if (st_q == brl_pkg::ST_SYNC && syncDone && syncOk) begin
      relPend_q <= 1'b0;
    end
  end

  // A deferred backend error waits for the next command; a new one wins.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      deferPend_q <= 1'b0;
    end else if (deferredErr) begin
      deferPend_q <= 1'b1;
    end else if (st_q == brl_pkg::ST_DEC) begin
      deferPend_q <= 1'b0;
    end
  end

  // Operator eject passes only while unlocked.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mechInhibit  <= 1'b0;
      ejectRelease <= 1'b0;
      ejectRefused <= 1'b0;
    end else begin
      mechInhibit  <= locked;
      ejectRelease <= ejectPress && !locked;
      ejectRefused <= ejectPress && locked;
    end
  end
endmodule
`default_nettype wire

// >>> design/brl_initiator.sv
// Initiator end: builds command blocks, issues them, and hands
// data and status back to its user.
// Assumes the target shares ref_clk, one command in flight.
`timescale 1ns/1ps
`default_nettype none
module brl_initiator (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  brl_link_if.initiator          link,
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire brl_pkg::brl_cmd_t cmdKind,
  input  wire logic [2:0]        cmdId,
  input  wire logic [31:0]       cmdLba,
  input  wire logic [15:0]       cmdCount,
  input  wire logic              cmdPrevent,
  input  wire logic              cmdDpo,
  input  wire logic              cmdFua,
  input  wire logic              cmdRelAdr,
  input  wire logic              cmdPmi,
  input  wire logic              cmdLink,
  input  wire logic              bdrReq,
  input  wire logic              rxReady,
  output logic                   rxValid,
  output logic [7:0]             rxByte,
  output logic                   doneValid,
  output logic [7:0]             doneStatus,
  output logic [3:0]             doneKey,
  output logic [7:0]             doneAsc
);
  logic              cdbValid_q;
  brl_pkg::brl_cdb_t cdb_q;
  logic [2:0]        id_q;
  logic              bdr_q;
  logic              dinReady_q;

  // Lays out one command block from the user's fields.
  function automatic brl_pkg::brl_cdb_t build(input brl_pkg::brl_cmd_t k);
    brl_pkg::brl_cdb_t c;
    c = '0;
    unique case (k)
      brl_pkg::CMD_PREVENT: begin
        c[0] = brl_pkg::OP_PREVENT;
        c[4] = {7'h00, cmdPrevent};
        c[5] = {7'h00, cmdLink};
      end
      brl_pkg::CMD_READ6: begin
        c[0] = brl_pkg::OP_READ6;
        c[1] = {3'h0, cmdLba[20:16]};
        c[2] = cmdLba[15:8];
        c[3] = cmdLba[7:0];
        c[4] = cmdCount[7:0];
        c[5] = {7'h00, cmdLink};
      end
      brl_pkg::CMD_READ10: begin
        c[0] = brl_pkg::OP_READ10;
        c[1] = {3'h0, cmdDpo, cmdFua, 2'h0, cmdRelAdr};
        {c[2], c[3], c[4], c[5]} = cmdLba;
        {c[7], c[8]} = cmdCount;
        c[9] = {7'h00, cmdLink};
      end
      brl_pkg::CMD_READCAP: begin
        c[0] = brl_pkg::OP_READCAP;
        c[1] = {7'h00, cmdRelAdr};
        {c[2], c[3], c[4], c[5]} = cmdLba;
        c[8] = {7'h00, cmdPmi};
        c[9] = {7'h00, cmdLink};
      end
    endcase
    build = c;
  endfunction

  assign link.cdbValid    = cdbValid_q;
  assign link.cdb         = cdb_q;
  assign link.initId      = id_q;
  assign link.busDevReset = bdr_q;
  assign link.dinReady    = dinReady_q;

  ////////////////////////////////////////////////////////////////////////////
  // One command in flight: accept, offer, await status.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmdReady   <= 1'b1;
      cdbValid_q <= 1'b0;
      cdb_q      <= '0;
      id_q       <= 3'h0;
    end else if (cmdValid && cmdReady) begin
      cmdReady   <= 1'b0;
      cdbValid_q <= 1'b1;
      cdb_q      <= build(cmdKind);
      id_q       <= cmdId;
    end else if (cdbValid_q && link.cdbReady) begin
      cdbValid_q <= 1'b0;
    end else if (link.staValid) begin
      cmdReady <= 1'b1;
    end
  end

  // Bus device reset goes out registered, following bdrReq a cycle late.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bdr_q <= 1'b0;
    end else begin
      bdr_q <= bdrReq;
    end
  end

  // Data bytes forwarded; user ready acts a cycle late.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dinReady_q <= 1'b0;
      rxValid    <= 1'b0;
      rxByte     <= 8'h00;
    end else begin
      dinReady_q <= rxReady;
      rxValid    <= link.dinValid && dinReady_q;
      rxByte     <= link.dinByte;
    end
  end

  // Final status and sense are held up for one cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      doneValid  <= 1'b0;
      doneStatus <= brl_pkg::STATUS_GOOD;
      doneKey    <= brl_pkg::KEY_NONE;
      doneAsc    <= brl_pkg::ASC_NONE;
    end else begin
      doneValid  <= link.staValid;
      doneStatus <= link.staCode;
      doneKey    <= link.senseKey;
      doneAsc    <= link.senseAsc;
    end
  end
endmodule
`default_nettype wire

// >>> verification/brl_link_properties.sv
// Link checker: status timing, capacity data, data-in hold.
// Assumes the testbench connects the link signals by name.
`timescale 1ns/1ps
`default_nettype none
module brl_link_properties (
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic              cdbValid,
  input wire logic              cdbReady,
  input wire brl_pkg::brl_cdb_t cdb,
  input wire logic              dinValid,
  input wire logic              dinReady,
  input wire logic [7:0]        dinByte,
  input wire logic              staValid,
  input wire logic [7:0]        staCode,
  input wire logic [3:0]        senseKey,
  input wire logic [7:0]        senseAsc
);
  localparam logic [19:0] OK  = {brl_pkg::STATUS_GOOD, brl_pkg::KEY_NONE, brl_pkg::ASC_NONE};
  localparam logic [19:0] BAD = {brl_pkg::STATUS_CHECK, brl_pkg::KEY_ILLEGAL, brl_pkg::ASC_BAD_FIELD};
  logic        tk;
  logic        capT;
  logic [31:0] adr;
  logic [19:0] sta;
  logic [3:0]  nB_q;
  logic        capC_q;
  logic        zC_q;
  // Decoded views of block and status.
  assign tk = cdbValid && cdbReady;
  assign capT = tk && cdb[0] == brl_pkg::OP_READCAP;
  assign adr = {cdb[2], cdb[3], cdb[4], cdb[5]};
  assign sta = {staCode, senseKey, senseAsc};
  // Counts data bytes since the last take.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nB_q <= 4'h0;
      capC_q <= 1'b0;
      zC_q <= 1'b0;
    end else if (tk) begin
      nB_q <= 4'h0;
      capC_q <= capT;
      zC_q <= cdb[0] == brl_pkg::OP_READ10 && {cdb[7], cdb[8]} == 16'h0000;
    end else if (dinValid && dinReady) begin
      nB_q <= nB_q + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_prevent_good: assert property (tk && cdb[0] == brl_pkg::OP_PREVENT && cdb[4][0] |-> ##[2:4] staValid && sta == OK)
    else $error("prevent status missing");
  chk_cap_illegal: assert property (capT && !cdb[8][0] && adr != 32'h0 |-> ##[2:40] staValid && sta == BAD)
    else $error("capacity field error not reported");
  chk_cap_last: assert property (capT && !cdb[8][0] && adr == 32'h0 |-> ##[4:60] staValid && sta == OK)
    else $error("capacity status missing");
  chk_cap_partial: assert property (capT && cdb[8][0] |-> ##[4:60] staValid && sta == OK)
    else $error("partial capacity status missing");
  chk_cap_bytes: assert property (staValid && capC_q && sta == OK |-> nB_q == 4'h8)
    else $error("capacity data not eight bytes");
  chk_zero_len: assert property (staValid && zC_q |-> nB_q == 4'h0 && sta == OK)
    else $error("zero length read moved data");
  chk_data_first: assert property (staValid |-> !dinValid)
    else $error("status while data pending");
  chk_din_hold: assert property (dinValid && !dinReady |=> dinValid && $stable(dinByte))
    else $error("data byte dropped in stall");
endmodule
`default_nettype wire

// >>> verification/block_read_and_removal_lock_cmds_tb.sv
// Bench for both ends with a one-byte-per-block backend.
// Assumes block bytes count up from the low address byte.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module block_read_and_removal_lock_cmds_tb;
  localparam logic [19:0] OK  = {brl_pkg::STATUS_GOOD, brl_pkg::KEY_NONE, brl_pkg::ASC_NONE};
  localparam logic [19:0] BAD = {brl_pkg::STATUS_CHECK, brl_pkg::KEY_ILLEGAL, brl_pkg::ASC_BAD_FIELD};
  int                failures = 0;
  int                cmp_count = 0;
  int                rdn = 0;
  logic              ref_clk = 1'b0, nrst = 1'b0, rdDone = 1'b0, syncDone = 1'b0, ejectPress = 1'b0;
  logic              bdrReq = 1'b0, rxReady = 1'b0, cmdValid = 1'b0;
  logic              rdReq, rdFromMedia, rdLowPri, rdDatReady, syncReq, ejectRelease, ejectRefused, mechInhibit;
  logic              cmdReady, rxValid, doneValid;
  logic [7:0]        rxByte, doneStatus, doneAsc, bb = 8'h00;
  logic [3:0]        doneKey, fl = 4'h0;
  logic [2:0]        cid = 3'h0;
  logic [31:0]       rdLba, lba = 32'h0, capLast = 32'h12345678, capLen = 32'h00000200, capDly = 32'h0;
  logic [15:0]       cnt = 16'h0;
  logic [16:0]       rdCount, left = 17'h0;
  logic [50:0]       lastRd;
  logic [19:0]       sta;
  logic [7:0]        rxq[$];
  brl_pkg::brl_cmd_t kind = brl_pkg::CMD_PREVENT;
  brl_link_if link ();
  brl_target brl_target_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link.target), .rdReq(rdReq), .rdLba(rdLba),
    .rdCount(rdCount), .rdFromMedia(rdFromMedia), .rdLowPri(rdLowPri), .rdDat(bb), .rdDatValid(left != 17'h0),
    .rdDatReady(rdDatReady), .rdDone(rdDone), .rdOk(1'b1), .syncReq(syncReq), .syncDone(syncDone), .syncOk(1'b1),
    .deferredErr(1'b0), .capLastLba(capLast), .capBlockLen(capLen), .capDelayLba(capDly), .ejectPress(ejectPress),
    .ejectRelease(ejectRelease), .ejectRefused(ejectRefused), .mechInhibit(mechInhibit));
  brl_initiator brl_initiator_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link.initiator), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(kind), .cmdId(cid), .cmdLba(lba), .cmdCount(cnt), .cmdPrevent(fl[3]),
    .cmdDpo(fl[2]), .cmdFua(fl[1]), .cmdRelAdr(1'b0), .cmdPmi(fl[0]), .cmdLink(1'b0), .bdrReq(bdrReq),
    .rxReady(rxReady), .rxValid(rxValid), .rxByte(rxByte), .doneValid(doneValid), .doneStatus(doneStatus),
    .doneKey(doneKey), .doneAsc(doneAsc));
  brl_link_properties brl_link_properties_inst (.ref_clk(ref_clk), .nrst(nrst), .cdbValid(link.cdbValid),
    .cdbReady(link.cdbReady), .cdb(link.cdb), .dinValid(link.dinValid), .dinReady(link.dinReady),
    .dinByte(link.dinByte), .staValid(link.staValid), .staCode(link.staCode), .senseKey(link.senseKey),
    .senseAsc(link.senseAsc));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, backend, sync answer, receiver stalling every other cycle.
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rxReady <= ~rxReady;
    syncDone <= syncReq;
    rdDone <= left == 17'h1 && rdDatReady;
    if (rdReq) begin
      left <= rdCount;
      bb <= rdLba[7:0];
      lastRd <= {rdCount, rdFromMedia, rdLowPri, rdLba};
      rdn++;
    end else if (left != 17'h0 && rdDatReady) begin
      left <= left - 17'h1;
      bb <= bb + 8'h1;
    end
  end
  // Collects user bytes.
  always @(negedge ref_clk) if (rxValid === 1'b1) rxq.push_back(rxByte);
  function automatic logic [63:0] pk();
    pk = 64'h0;
    foreach (rxq[j]) pk = {pk[55:0], rxq[j]};
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Issues one command (flags prevent, dpo, fua, pmi) and waits for status.
  task automatic iss(brl_pkg::brl_cmd_t k, logic [2:0] i, logic [31:0] a, logic [15:0] n, logic [3:0] f);
    int w;
    rxq.delete();
    @(posedge ref_clk);
    kind <= k;
    cid <= i;
    lba <= a;
    cnt <= n;
    fl <= f;
    cmdValid <= 1'b1;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    for (w = 0; w < 3000 && doneValid !== 1'b1; w++) @(negedge ref_clk);
    if (w == 3000) begin
      failures++;
      end_sim();
    end
    sta = {doneStatus, doneKey, doneAsc};
  endtask
  task automatic eject(logic [2:0] e);
    @(posedge ref_clk);
    ejectPress <= 1'b1;
    @(posedge ref_clk);
    ejectPress <= 1'b0;
    @(negedge ref_clk);
    `CHK({ejectRefused, ejectRelease, mechInhibit}, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Capacity: last block, bad field, partial floor.
  task automatic t_cap();
    @(posedge ref_clk);
    capDly <= 32'h00000040;
    iss(brl_pkg::CMD_READCAP, 3'h0, 32'h0, 16'h0, 4'h0);
    `CHK(sta, OK)
    `CHK(pk(), 64'h12345678_00000200)
    `CHK(rxq.size(), 8)
    iss(brl_pkg::CMD_READCAP, 3'h0, 32'h5, 16'h0, 4'h0);
    `CHK(sta, BAD)
    iss(brl_pkg::CMD_READCAP, 3'h0, 32'h50, 16'h0, 4'h1);
    `CHK(pk(), 64'h00000050_00000200)
    iss(brl_pkg::CMD_READCAP, 3'h0, 32'h30, 16'h0, 4'h1);
    `CHK(pk(), 64'h00000040_00000200)
    $display("t_cap done");
  endtask
  // Reads: 256-block short read, flagged and empty long reads.
  task automatic t_read();
    int r;
    iss(brl_pkg::CMD_READ6, 3'h0, 32'h1F0, 16'h0, 4'h0);
    `CHK(lastRd, {17'h00100, brl_pkg::READ6_FROM_MEDIA, brl_pkg::READ6_LOW_PRI, 32'h1F0})
    `CHK(rxq.size(), 256)
    `CHK(rxq[255], 8'hEF)
    `CHK(sta, OK)
    iss(brl_pkg::CMD_READ10, 3'h0, 32'h89ABCDEF, 16'h3, 4'h6);
    `CHK(lastRd, {17'h3, 1'b1, 1'b1, 32'h89ABCDEF})
    `CHK(pk(), 64'hEFF0F1)
    iss(brl_pkg::CMD_READ10, 3'h0, 32'h10, 16'h1, 4'h0);
    `CHK(lastRd, {17'h1, 1'b0, 1'b0, 32'h10})
    r = rdn;
    iss(brl_pkg::CMD_READ10, 3'h0, 32'h10, 16'h0, 4'h0);
    `CHK(rdn, r)
    `CHK(sta, OK)
    $display("t_read done");
  endtask
  // Locks from two initiators, release, then bus reset.
  task automatic t_lock();
    iss(brl_pkg::CMD_PREVENT, 3'h1, 32'h0, 16'h0, 4'h8);
    iss(brl_pkg::CMD_PREVENT, 3'h2, 32'h0, 16'h0, 4'h8);
    eject(3'b101);
    iss(brl_pkg::CMD_PREVENT, 3'h1, 32'h0, 16'h0, 4'h0);
    eject(3'b101);
    iss(brl_pkg::CMD_PREVENT, 3'h2, 32'h0, 16'h0, 4'h0);
    eject(3'b010);
    iss(brl_pkg::CMD_PREVENT, 3'h3, 32'h0, 16'h0, 4'h8);
    @(posedge ref_clk);
    bdrReq <= 1'b1;
    @(posedge ref_clk);
    bdrReq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    eject(3'b010);
    $display("t_lock done");
  endtask
  // Reset for six cycles, then the scenarios.
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_cap();
    t_read();
    t_lock();
    end_sim();
  end
endmodule
`default_nettype wire
